//--- src/sitd_xfer_state.sv
// sitd_xfer_state: transfer status and control of one split isochronous
// descriptor, reached over apb, driven by the split transaction engine.
// assumes: engine strobes are one-cycle pulses on CLK; tt data arrives
// on CLK; software fills the descriptor words before setting active.
`timescale 1ns/1ps

// Functional notes
// - with ioc set, completion raises an interrupt at the next threshold; otherwise none.
// - page select picks page 0 or page 1 pointer for the data address.
// - page select need not be written back when the descriptor retires.
// - complete-split progress mask records each complete-split carried out.
// - descriptor executes only while software's active bit is set.
// - error handshake from the translator sets the error-response bit.
// - underrun, or overrun while active, sets the data buffer error bit.
// - underrun forces a corrupted crc; overrun needs nothing more.
// - babble in this descriptor's transaction sets the babble bit.
// - no valid response sets transaction error, for in transfers only.
// - host hold-off missing a complete-split sets the missed micro-frame bit.
// - split state zero issues start-split on s-mask, one complete-split on c-mask.
// - low three bits of the next frame index select the s-mask and c-mask bit.
module sitd_xfer_state
	import sitd_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// micro-frame timing
	input  wire logic        UFRAME_TICK,
	input  wire logic        IRQ_THRESHOLD,
	// split engine requests and results
	output logic             START_SPLIT,
	output logic             COMPLETE_SPLIT,
	input  wire logic        START_DONE,
	input  wire logic        COMPLETE_DONE,
	input  wire logic        COMPLETE_LAST,
	input  wire logic [9:0]  BYTES_MOVED,
	input  wire logic        ERR_HANDSHAKE,
	input  wire logic        TX_UNDERRUN,
	input  wire logic        BABBLE,
	input  wire logic        NO_RESPONSE,
	input  wire logic        HOLDOFF_MISS,
	output logic             CORRUPT_CRC,
	output logic             IRQ,
	output logic [31:0]      DATA_ADDR,
	// received data into the fifo, drained toward memory
	input  wire logic        RX_VALID,
	output logic             RX_READY,
	input  wire logic [31:0] RX_DATA,
	output logic             MEM_VALID,
	input  wire logic        MEM_READY,
	output logic [31:0]      MEM_DATA
);

	// =====================================================================
	// reset release: asserts at once, releases through two flops
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// =====================================================================
	// state
	logic [31:0]        xfer_state_reg;
	logic [31:0]        xfer_state_next;
	logic [15:0]        sched_mask_reg;
	logic [31:0]        page0_reg;
	logic [31:0]        page1_reg;
	logic [FRIDX_W-1:0] frame_index_counter_reg;
	logic [FRIDX_W-1:0] frame_index_counter_next;
	logic               dir_in_reg;
	logic               irq_pend_reg;
	logic               irq_pend_next;
	logic               irq_reg;
	logic               crc_bad_reg;
	logic               start_reg;
	logic               compl_reg;
	logic [31:0]        prdata_reg;
	logic               slverr_reg;
	split_fsm_t         fsm_reg;
	split_fsm_t         fsm_next;

	// =====================================================================
	// apb decode; zero wait states, every access finishes in its access cycle
	logic apb_access;
	logic apb_wr;
	logic apb_rd;
	logic addr_hit;

	function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
		sel = (a == ofs);
	endfunction

	assign apb_access = PSEL && PENABLE;
	assign apb_wr     = apb_access && PWRITE && addr_hit;
	assign apb_rd     = apb_access && !PWRITE;
	assign addr_hit   = sel(PADDR, OFS_XFER_STATE) || sel(PADDR, OFS_SCHED_MASK)
		|| sel(PADDR, OFS_PAGE0) || sel(PADDR, OFS_PAGE1)
		|| sel(PADDR, OFS_FRAME_IDX) || sel(PADDR, OFS_CTRL);
	assign PREADY     = 1'b1;

	logic wr_xs;
	logic wr_sched;
	logic wr_p0;
	logic wr_p1;
	logic wr_fidx;
	logic wr_ctrl;

	assign wr_xs    = apb_wr && sel(PADDR, OFS_XFER_STATE);
	assign wr_sched = apb_wr && sel(PADDR, OFS_SCHED_MASK);
	assign wr_p0    = apb_wr && sel(PADDR, OFS_PAGE0);
	assign wr_p1    = apb_wr && sel(PADDR, OFS_PAGE1);
	assign wr_fidx  = apb_wr && sel(PADDR, OFS_FRAME_IDX);
	assign wr_ctrl  = apb_wr && sel(PADDR, OFS_CTRL);

	// =====================================================================
	// fifo in the receive path; a refused word is a receive overrun
	logic fifo_full;
	logic fifo_empty;
	logic rx_overrun;

	sitd_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_rx_fifo (
		.clk       (CLK),
		.rst_n     (rst_n_reg),
		.in_valid  (RX_VALID),
		.in_ready  (RX_READY),
		.in_data   (RX_DATA),
		.out_valid (MEM_VALID),
		.out_ready (MEM_READY),
		.out_data  (MEM_DATA),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	// isochronous data cannot wait, so a stalled word is lost, and flagged while active
	assign rx_overrun = RX_VALID && !RX_READY;

	// =====================================================================
	// micro-frame selection of the split masks
	logic [UF_SEL_W-1:0] uf_sel;
	logic                active;
	logic                split_state;
	logic                smask_hit;
	logic                cmask_hit;
	logic [MASK_W-1:0]   cprog;
	logic [MASK_W-1:0]   uf_onehot;

	assign frame_index_counter_next = frame_index_counter_reg + FRIDX_W'(1);
	assign uf_sel      = frame_index_counter_next[UF_SEL_W-1:0];
	assign uf_onehot   = MASK_W'(1) << uf_sel;
	assign active      = xfer_state_reg[ST_ACTIVE];
	assign split_state = xfer_state_reg[ST_SPLIT];
	assign cprog       = xfer_state_reg[XS_CPROG_LO +: MASK_W];
	assign smask_hit   = |(sched_mask_reg[MASK_W-1:0] & uf_onehot);
	assign cmask_hit   = |(sched_mask_reg[SCHED_CMASK_LO +: MASK_W] & uf_onehot);

	// =====================================================================
	// split engine state machine
	logic issue_start;
	logic issue_compl;
	logic retire;

	// requests only go out on a micro-frame boundary while active
	assign issue_start = UFRAME_TICK && active && !split_state && smask_hit;
	assign issue_compl = UFRAME_TICK && active && split_state && cmask_hit;
	// an error handshake ends the transfer as a completion does
	assign retire      = active && ((COMPLETE_DONE && COMPLETE_LAST) || ERR_HANDSHAKE);

	always_comb begin
		fsm_next = fsm_reg;
		case (fsm_reg)
			SPLIT_IDLE: begin
				if (issue_start)
					fsm_next = SPLIT_START;
				else if (issue_compl)
					fsm_next = SPLIT_COMPL;
			end
			SPLIT_START: begin
				if (START_DONE || ERR_HANDSHAKE || !active)
					fsm_next = SPLIT_IDLE;
			end
			SPLIT_COMPL: begin
				if (COMPLETE_DONE || ERR_HANDSHAKE || !active)
					fsm_next = SPLIT_IDLE;
			end
			default: fsm_next = SPLIT_IDLE;
		endcase
	end

	// =====================================================================
	// transfer state word update: software write first, hardware sets after,
	// so a flag set in the cycle software rewrites the word is kept
	logic [XS_TOTAL_W-1:0] total_left;
	logic                  flag_buf;
	logic                  flag_xact;

	assign total_left = xfer_state_reg[XS_TOTAL_LO +: XS_TOTAL_W];
	assign flag_buf   = TX_UNDERRUN || (rx_overrun && active);
	assign flag_xact  = NO_RESPONSE && dir_in_reg;

	always_comb begin
		xfer_state_next = xfer_state_reg;
		if (wr_xs)
			xfer_state_next = PWDATA & XS_WRITABLE; // reserved bits held at zero
		if (fsm_reg == SPLIT_START && START_DONE)
			xfer_state_next[ST_SPLIT] = 1'b1;
		if (issue_compl && fsm_reg == SPLIT_IDLE)
			xfer_state_next[XS_CPROG_LO +: MASK_W] = cprog | uf_onehot;
		if (COMPLETE_DONE)
			xfer_state_next[XS_TOTAL_LO +: XS_TOTAL_W] =
				(BYTES_MOVED > total_left) ? '0 : total_left - BYTES_MOVED;
		if (ERR_HANDSHAKE)
			xfer_state_next[ST_ERR_RESP] = 1'b1;
		if (flag_buf)
			xfer_state_next[ST_BUF_ERR] = 1'b1;
		if (BABBLE)
			xfer_state_next[ST_BABBLE] = 1'b1;
		if (flag_xact)
			xfer_state_next[ST_XACT_ERR] = 1'b1;
		if (HOLDOFF_MISS && split_state)
			xfer_state_next[ST_MISSED_UF] = 1'b1;
		if (retire) begin
			// error bits stay; page select is left as software put it
			xfer_state_next[ST_ACTIVE] = 1'b0;
			xfer_state_next[ST_SPLIT]  = 1'b0;
		end
	end

	// interrupt pends on completion with ioc, fires at the next threshold
	assign irq_pend_next = (retire && xfer_state_reg[XS_IOC_BIT])
		|| (irq_pend_reg && !IRQ_THRESHOLD);

	// =====================================================================
	// data address from the selected page pointer and the running offset
	logic [31:0]         page_sel_ptr;
	logic [OFFSET_W-1:0] cur_offset;
	logic [OFFSET_W-1:0] current_byte_offset;

	assign cur_offset          = page0_reg[OFFSET_W-1:0];
	assign current_byte_offset = cur_offset + OFFSET_W'(BYTES_MOVED);
	assign page_sel_ptr        = xfer_state_reg[XS_PAGE_BIT] ? page1_reg : page0_reg;
	assign DATA_ADDR           = {page_sel_ptr[31:PAGE_PTR_LO], cur_offset};

	// =====================================================================
	// read mux; unmapped addresses read zero with an error
	logic [31:0] rd_mux;
	logic [31:0] ctrl_view;

	assign ctrl_view = {21'h0, irq_pend_reg, fifo_full, fifo_empty, 7'h0, dir_in_reg};
	assign rd_mux =
		sel(PADDR, OFS_XFER_STATE) ? xfer_state_reg :
		sel(PADDR, OFS_SCHED_MASK) ? {16'h0, sched_mask_reg} :
		sel(PADDR, OFS_PAGE0)      ? page0_reg :
		sel(PADDR, OFS_PAGE1)      ? page1_reg :
		sel(PADDR, OFS_FRAME_IDX)  ? {18'h0, frame_index_counter_reg} :
		sel(PADDR, OFS_CTRL)       ? ctrl_view : 32'h0000_0000;

	// =====================================================================
	// descriptor registers
	always_ff @(posedge CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			xfer_state_reg <= RST_WORD;
			sched_mask_reg <= RST_WORD[15:0];
			page0_reg      <= RST_WORD;
			page1_reg      <= RST_WORD;
			dir_in_reg     <= 1'b0;
		end else begin
			xfer_state_reg <= xfer_state_next;
			if (wr_sched)
				sched_mask_reg <= PWDATA[15:0];
			if (wr_p0)
				page0_reg <= PWDATA;
			else if (COMPLETE_DONE)
				page0_reg[OFFSET_W-1:0] <= current_byte_offset;
			if (wr_p1)
				page1_reg <= PWDATA;
			if (wr_ctrl)
				dir_in_reg <= PWDATA[CTRL_DIR_IN];
		end
	end

	// frame index runs on every micro-frame tick; software may preload it
	always_ff @(posedge CLK or negedge rst_n_reg) begin
		if (!rst_n_reg)
			frame_index_counter_reg <= RST_FRIDX;
		else if (wr_fidx)
			frame_index_counter_reg <= PWDATA[FRIDX_W-1:0];
		else if (UFRAME_TICK)
			frame_index_counter_reg <= frame_index_counter_next;
	end

	// split machine and request strobes
	always_ff @(posedge CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			fsm_reg   <= SPLIT_IDLE;
			start_reg <= 1'b0;
			compl_reg <= 1'b0;
		end else begin
			fsm_reg   <= fsm_next;
			start_reg <= issue_start && fsm_reg == SPLIT_IDLE;
			compl_reg <= issue_compl && fsm_reg == SPLIT_IDLE;
		end
	end

	// interrupt and crc corruption; underrun data must not be accepted
	always_ff @(posedge CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_pend_reg <= 1'b0;
			irq_reg      <= 1'b0;
			crc_bad_reg  <= 1'b0;
		end else begin
			irq_pend_reg <= irq_pend_next;
			irq_reg      <= irq_pend_reg && IRQ_THRESHOLD;
			crc_bad_reg  <= TX_UNDERRUN;
		end
	end

	// apb read data and error, registered in the setup cycle
	always_ff @(posedge CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else begin
			prdata_reg <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : prdata_reg;
			slverr_reg <= PSEL && !PENABLE && !addr_hit;
		end
	end

	// =====================================================================
	// outputs
	assign PRDATA         = apb_rd ? prdata_reg : 32'h0000_0000;
	assign PSLVERR        = apb_access && slverr_reg;
	assign START_SPLIT    = start_reg;
	assign COMPLETE_SPLIT = compl_reg;
	assign CORRUPT_CRC    = crc_bad_reg;
	assign IRQ            = irq_reg;

endmodule // sitd_xfer_state

//--- include/sitd_pkg.sv
// sitd_pkg: constants for the split isochronous transfer state block.
// assumes: 32-bit apb, one aligned word per register, single clock.
package sitd_pkg;

	// =====================================================================
	// register byte offsets
	localparam logic [7:0] OFS_XFER_STATE = 8'h00; // transfer status and control word
	localparam logic [7:0] OFS_SCHED_MASK = 8'h04; // start / complete split masks
	localparam logic [7:0] OFS_PAGE0      = 8'h08; // page 0 pointer and byte offset
	localparam logic [7:0] OFS_PAGE1      = 8'h0c; // page 1 pointer
	localparam logic [7:0] OFS_FRAME_IDX  = 8'h10; // frame index counter
	localparam logic [7:0] OFS_CTRL       = 8'h14; // direction and fifo status

	// =====================================================================
	// transfer state word fields
	localparam int XS_IOC_BIT    = 31;
	localparam int XS_PAGE_BIT   = 30;
	localparam int XS_TOTAL_LO   = 16;
	localparam int XS_TOTAL_W    = 10;
	localparam int XS_CPROG_LO   = 8;
	localparam int ST_ACTIVE     = 7;
	localparam int ST_ERR_RESP   = 6;
	localparam int ST_BUF_ERR    = 5;
	localparam int ST_BABBLE     = 4;
	localparam int ST_XACT_ERR   = 3;
	localparam int ST_MISSED_UF  = 2;
	localparam int ST_SPLIT      = 1;
	localparam logic [31:0] XS_WRITABLE = 32'hc3ff_fffe; // reserved 29..26 and 0 drop

	// =====================================================================
	// other field positions and widths
	localparam int MASK_W        = 8;
	localparam int SCHED_CMASK_LO = 8;
	localparam int PAGE_PTR_LO   = 12;
	localparam int OFFSET_W      = 12;
	localparam int FRIDX_W       = 14;
	localparam int UF_SEL_W      = 3;
	localparam int CTRL_DIR_IN   = 0;
	localparam int CTRL_FIFO_EMPTY = 8;
	localparam int CTRL_FIFO_FULL  = 9;
	localparam int CTRL_IRQ_PEND   = 10;

	// =====================================================================
	// reset values
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [FRIDX_W-1:0] RST_FRIDX = 14'h0000;

	// =====================================================================
	// data fifo
	localparam int FIFO_W = 32;
	localparam int FIFO_D = 4;

	// split engine states
	typedef enum logic [2:0] {
		SPLIT_IDLE  = 3'b001,
		SPLIT_START = 3'b010,
		SPLIT_COMPL = 3'b100
	} split_fsm_t;

endpackage

//--- src/sitd_fifo.sv
// sitd_fifo: small flip-flop fifo with valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset released on that clock.
`timescale 1ns/1ps

module sitd_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic              full,
	output logic              empty
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0]  mem_reg [D];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;

	// =====================================================================
	// handshake decode
	assign full      = (count_reg == (AW+1)'(D));
	assign empty     = (count_reg == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// pointers wrap at depth; depth need not be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + AW'(1);
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage carries no reset; empty gates every read
	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

endmodule // sitd_fifo

//--- sim/sitd_xfer_state_asserts.sv
// sitd_xfer_state_asserts: port checker for the transfer state block.
// assumes: bound to sitd_xfer_state, one CLK domain, RESETN active low.
`timescale 1ns/1ps

module sitd_xfer_state_asserts (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic        UFRAME_TICK,
	input wire logic        IRQ_THRESHOLD,
	input wire logic        START_SPLIT,
	input wire logic        COMPLETE_SPLIT,
	input wire logic        COMPLETE_DONE,
	input wire logic        TX_UNDERRUN,
	input wire logic        CORRUPT_CRC,
	input wire logic        IRQ,
	input wire logic [31:0] DATA_ADDR,
	input wire logic        RX_VALID,
	input wire logic        RX_READY,
	input wire logic        MEM_VALID
);
	// =====================================================================
	// sequences
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// a split request of either kind
	sequence s_issue;
		START_SPLIT || COMPLETE_SPLIT;
	endsequence
	// the bad crc follows one cycle later
	sequence s_crc_next;
		##1 CORRUPT_CRC;
	endsequence

	// =====================================================================
	// split issue follows its tick only
	AST_START_CAUSE: assert property (START_SPLIT |-> $past(UFRAME_TICK))
		else $error("start split without a tick");
	AST_COMPL_CAUSE: assert property (COMPLETE_SPLIT |-> $past(UFRAME_TICK))
		else $error("complete split without a tick");
	// ticks are sparse, so a request is a single-cycle pulse of one kind
	AST_ISSUE_PULSE: assert property (s_issue |=> !(START_SPLIT || COMPLETE_SPLIT))
		else $error("split request longer than one cycle");
	AST_CRC_FOLLOWS: assert property (TX_UNDERRUN |-> s_crc_next)
		else $error("underrun without corrupted crc");
	AST_CRC_CAUSE: assert property (CORRUPT_CRC |-> $past(TX_UNDERRUN))
		else $error("corrupted crc without underrun");
	AST_IRQ_CAUSE: assert property (IRQ |-> $past(IRQ_THRESHOLD))
		else $error("interrupt away from threshold");
	AST_IRQ_PULSE: assert property (IRQ |=> !IRQ)
		else $error("interrupt longer than one cycle");
	// address moves only by a register write or a completed transfer
	AST_ADDR_CAUSE: assert property ($changed(DATA_ADDR) |->
		($past(PSEL) && $past(PENABLE) && $past(PWRITE)) || $past(COMPLETE_DONE))
		else $error("data address changed without cause");
	AST_FIFO_FILL: assert property (RX_VALID && RX_READY && !MEM_VALID |=> MEM_VALID)
		else $error("accepted word not offered");
endmodule // sitd_xfer_state_asserts

bind sitd_xfer_state sitd_xfer_state_asserts i_chk (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .UFRAME_TICK(UFRAME_TICK),
	.IRQ_THRESHOLD(IRQ_THRESHOLD), .START_SPLIT(START_SPLIT),
	.COMPLETE_SPLIT(COMPLETE_SPLIT), .COMPLETE_DONE(COMPLETE_DONE),
	.TX_UNDERRUN(TX_UNDERRUN), .CORRUPT_CRC(CORRUPT_CRC), .IRQ(IRQ),
	.DATA_ADDR(DATA_ADDR), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .MEM_VALID(MEM_VALID));

//--- sim/sitd_tt_model.sv
// sitd_tt_model: full-speed endpoint behind a hub translator, as seen
// by the split engine. assumes: requests are one-cycle pulses on clk.
`timescale 1ns/1ps

module sitd_tt_model (
	input  wire logic       clk,
	input  wire logic       start_split,
	input  wire logic       complete_split,
	input  wire logic [3:0] lat,
	input  wire logic       err_mode,
	input  wire logic [9:0] bytes,
	output logic            start_done,
	output logic            complete_done,
	output logic            complete_last,
	output logic [9:0]      bytes_moved,
	output logic            err_handshake
);
	logic [3:0] wait_cnt = 4'h0;
	logic       busy = 1'b0;
	logic       is_cpl = 1'b0;

	// =====================================================================
	// answers only what was asked, lat+2 cycles after the request; error only on command
	// one process drives every output; garbage count outside a completion
	always @(posedge clk) begin
		{start_done, complete_done, complete_last, err_handshake} <= 4'h0;
		bytes_moved <= ~bytes; // no stale count outside a completion
		if (start_split || complete_split) begin
			busy <= 1'b1;
			is_cpl <= complete_split;
			wait_cnt <= lat;
		end else if (busy && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			if (!is_cpl)
				start_done <= 1'b1;
			else if (err_mode)
				err_handshake <= 1'b1;
			else begin
				complete_done <= 1'b1;
				complete_last <= 1'b1;
				bytes_moved <= bytes;
			end
		end
	end
endmodule // sitd_tt_model

//--- sim/sitd_xfer_state_tb.sv
// sitd_xfer_state_tb: register, split, status and fifo tests over apb.
// assumes: design and package compiled first, checker bound to the dut.
`timescale 1ns/1ps

module sitd_xfer_state_tb;
	import sitd_pkg::*;
	logic        CLK = 1'b0, RESETN = 1'b0;
	logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, DATA_ADDR, RX_DATA = 32'h0, MEM_DATA;
	logic        PREADY, PSLVERR, START_SPLIT, COMPLETE_SPLIT, CORRUPT_CRC, IRQ;
	logic        START_DONE, COMPLETE_DONE, COMPLETE_LAST, ERR_HANDSHAKE;
	logic        RX_VALID = 1'b0, RX_READY, MEM_VALID, MEM_READY = 1'b0;
	logic [9:0]  BYTES_MOVED;
	logic [5:0]  ev = 6'h00;
	logic [3:0]  lat = 4'h1;
	logic        err_mode = 1'b0;
	wire logic   UFRAME_TICK = ev[0], IRQ_THRESHOLD = ev[1], TX_UNDERRUN = ev[2];
	wire logic   BABBLE = ev[3], NO_RESPONSE = ev[4], HOLDOFF_MISS = ev[5];
	int          err_total = 0, checked = 0, cyc = 0, n_acc = 0;
	int          n_st = 0, n_cs = 0, n_irq = 0, n_crc = 0, n_sd = 0, n_fin = 0;

	sitd_xfer_state i_dut (.*);
	sitd_tt_model i_tt (.clk(CLK), .start_split(START_SPLIT), .complete_split(COMPLETE_SPLIT),
		.lat(lat), .err_mode(err_mode), .bytes(10'd40), .start_done(START_DONE),
		.complete_done(COMPLETE_DONE), .complete_last(COMPLETE_LAST),
		.bytes_moved(BYTES_MOVED), .err_handshake(ERR_HANDSHAKE));

	// =====================================================================
	// clock, pulse counters, hang limit well above the run of under two hundred cycles
	always #2.5 CLK = ~CLK;
	always @(posedge CLK) begin
		n_st += (START_SPLIT === 1'b1);
		n_cs += (COMPLETE_SPLIT === 1'b1);
		n_irq += (IRQ === 1'b1);
		n_crc += (CORRUPT_CRC === 1'b1);
		n_sd += (START_DONE === 1'b1);
		n_fin += (COMPLETE_DONE === 1'b1 || ERR_HANDSHAKE === 1'b1);
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end

	// =====================================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge after it keeps drivers from clashing
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge CLK);
		ev[k] <= 1'b0;
		repeat (2) @(posedge CLK);
	endtask
	task automatic await_n(ref int n, input int x);
		for (int i = 0; i < 64 && n < x; i++) @(posedge CLK);
		repeat (2) @(posedge CLK);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// =====================================================================
	// main sequence
	initial begin
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(OFS_XFER_STATE, RST_WORD, 1'b0);
		wr(OFS_XFER_STATE, 32'hfc00_0001);
		rd(OFS_XFER_STATE, 32'hc000_0000, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		$display("test registers done");
		wr(OFS_PAGE0, 32'h1234_5abc);
		wr(OFS_PAGE1, 32'habcd_e000);
		wr(OFS_XFER_STATE, 32'h4000_0000);
		chk(DATA_ADDR, 32'habcd_eabc);
		wr(OFS_XFER_STATE, 32'h0);
		chk(DATA_ADDR, 32'h1234_5abc);
		$display("test page select done");
		// s-mask bit 1, c-mask bit 3; prompt endpoint
		wr(OFS_SCHED_MASK, 32'h0000_0802);
		wr(OFS_FRAME_IDX, 32'h0);
		wr(OFS_XFER_STATE, 32'h8064_0080);
		pulse(0);
		await_n(n_sd, 1);
		rd(OFS_XFER_STATE, 32'h8064_0082, 1'b0);
		pulse(0);
		pulse(0);
		await_n(n_fin, 1);
		rd(OFS_XFER_STATE, 32'h803c_0800, 1'b0);
		chk(DATA_ADDR, 32'h1234_5ae4);
		pulse(1);
		wr(OFS_FRAME_IDX, 32'h0);
		pulse(0);
		chk(n_irq, 1);
		chk(n_st, 1);
		chk(n_cs, 1);
		$display("test split flow done");
		// slow endpoint, faults in flight, error handshake retires
		wr(OFS_CTRL, 32'h1);
		lat <= 4'h5;
		wr(OFS_FRAME_IDX, 32'h0);
		wr(OFS_XFER_STATE, 32'h0000_0080);
		pulse(0);
		await_n(n_sd, 2);
		for (int k = 2; k < 6; k++) pulse(k);
		err_mode <= 1'b1;
		pulse(0);
		pulse(0);
		await_n(n_fin, 2);
		rd(OFS_XFER_STATE, 32'h0000_087c, 1'b0);
		pulse(1);
		chk(n_crc, 1);
		chk(n_irq, 1);
		$display("test fault status done");
		// fill with the memory side stalled, then drain
		for (int i = 0; i < 6; i++) begin
			RX_VALID <= 1'b1;
			RX_DATA <= 32'h0000_00a0 + i;
			@(posedge CLK);
			n_acc += (RX_READY === 1'b1);
		end
		RX_VALID <= 1'b0;
		MEM_READY <= 1'b1;
		chk(n_acc, 4);
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			chk({MEM_VALID, MEM_DATA[30:0]}, 32'h8000_00a0 + i);
		end
		@(posedge CLK);
		chk({31'h0, MEM_VALID}, 32'h0);
		rd(OFS_CTRL, 32'h0000_0101, 1'b0);
		$display("test fifo done");
		complete_run();
	end
endmodule // sitd_xfer_state_tb
